/* File: verilog/rtc_defs.svh */
/*
 * register offsets, reset values and timing counts
 * for the alarm, watchdog and square-wave section of the clock.
 * assumes byte-wide registers reached by an 8-bit register address.
 */
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// ==========================================================
// register offsets
`define RTC_ADDR_SECONDS 8'h01
`define RTC_ADDR_CENTURY_HOURS 8'h03
`define RTC_ADDR_CONTROL 8'h08
`define RTC_ADDR_WATCHDOG 8'h09
`define RTC_ADDR_ALARM_MONTH 8'h0a
`define RTC_ADDR_ALARM_DATE 8'h0b
`define RTC_ADDR_ALARM_HOUR 8'h0c
`define RTC_ADDR_ALARM_MIN 8'h0d
`define RTC_ADDR_ALARM_SEC 8'h0e
`define RTC_ADDR_FLAGS 8'h0f
`define RTC_ADDR_SQW_RATE 8'h13

// ==========================================================
// reset values after first power application
`define RTC_RST_CONTROL 8'h80
`define RTC_RST_WATCHDOG 7'h00
`define RTC_RST_ALARM_MONTH 8'h00
`define RTC_RST_ALARM_DATE 8'h00
`define RTC_RST_ALARM_HOUR 8'h40
`define RTC_RST_ALARM_MIN 8'h00
`define RTC_RST_ALARM_SEC 8'h00
`define RTC_RST_SQW_RATE 4'h0

// ==========================================================
// timing: watchdog base in oscillator periods, frequency-test divider bit index
`define RTC_WD_BASE_TICKS 2048
`define RTC_FTEST_BIT 5

`endif

/* File: verilog/rtc_pkg.sv */
/*
 * types shared by the alarm, watchdog and square-wave block.
 * assumes the constants header is included by the design files.
 */
package rtc_pkg;

    // ======================================================
    // source steering the multi-function pin
    typedef enum logic [2:0] {
        RTC_SRC_RELEASE = 3'b000,
        RTC_SRC_SQW = 3'b001,
        RTC_SRC_ALARM = 3'b010,
        RTC_SRC_WDOG = 3'b011,
        RTC_SRC_FTEST = 3'b100,
        RTC_SRC_OUT = 3'b101
    } rtc_pin_src_t;

endpackage

/* File: verilog/rtc_event_ctrl.sv */
/*
 * alarm comparator, watchdog, square-wave divider, century toggle and
 * multi-function pin arbitration of a serial real-time clock.
 * assumes the serial bus engine hands over decoded register reads and
 * writes with the live register pointer, and the calendar supplies
 * its BCD time plus a one-cycle tick whenever the seconds change.
 */
`timescale 1ns/1ps
`include "rtc_defs.svh"

module rtc_event_ctrl
    import rtc_pkg::*;
#(
    parameter int P_WD_BASE_TICKS = `RTC_WD_BASE_TICKS
)
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // oscillator and power state
    input wire logic i_osc_32k,
    input wire logic i_power_up,
    input wire logic i_backup_mode,
    // register access from the bus engine
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_ptr,
    output logic [7:0] o_reg_rdata,
    // current time from the calendar, BCD
    input wire logic i_sec_tick,
    input wire logic i_century_tick,
    input wire logic [6:0] i_cur_sec,
    input wire logic [6:0] i_cur_min,
    input wire logic [5:0] i_cur_hour,
    input wire logic [5:0] i_cur_date,
    input wire logic [4:0] i_cur_month,
    // control bits for the calendar section
    output logic o_oscillator_halt_bit,
    output logic o_update_freeze_bit,
    output logic o_century_bit,
    // multi-function pin, open drain
    output logic o_multi_function_pin,
    output logic o_multi_function_pin_oe_n
);

    // ======================================================
    // helpers
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // undefined codes fall back to every second
    function automatic logic [4:0] norm_rpt(input logic [4:0] r);
        unique case (r)
            5'h1f, 5'h1e, 5'h1c, 5'h18, 5'h10, 5'h00: norm_rpt = r;
            default: norm_rpt = 5'h1f;
        endcase
    endfunction

    // ======================================================
    // registers
    logic [7:0] control_q;
    logic [6:0] watchdog_q;
    logic [7:0] alarm_month_q;
    logic [7:0] alarm_date_q;
    logic [7:0] alarm_hour_q;
    logic [7:0] alarm_min_q;
    logic [7:0] alarm_sec_q;
    logic [3:0] square_wave_rate_sel_q;
    logic oscillator_halt_bit_q;
    logic century_toggle_enable_q;
    logic century_bit_q;
    logic alarm_flag_q;
    logic watchdog_flag_q;
    logic alarm_irq_q;
    logic wd_irq_q;
    logic [7:0] rdata_q;

    logic wr_en;
    logic rd_en;
    logic flags_read;
    logic wd_write;
    assign wr_en = i_reg_wr;
    assign rd_en = i_reg_rd;
    assign flags_read = rd_en && hit(i_reg_addr, `RTC_ADDR_FLAGS);
    assign wd_write = wr_en && hit(i_reg_addr, `RTC_ADDR_WATCHDOG);

    logic out_bit;
    logic freq_test_bit;
    logic alarm_irq_enable;
    logic square_wave_enable;
    logic alarm_backup_enable;
    logic update_freeze_bit;
    logic [4:0] watchdog_multiplier;
    logic [1:0] watchdog_resolution;
    assign out_bit = control_q[7];
    assign freq_test_bit = control_q[6];
    assign alarm_irq_enable = alarm_month_q[7];
    assign square_wave_enable = alarm_month_q[6];
    assign alarm_backup_enable = alarm_month_q[5];
    assign update_freeze_bit = alarm_hour_q[6];
    assign watchdog_multiplier = watchdog_q[6:2];
    assign watchdog_resolution = watchdog_q[1:0];

    // ======================================================
    // oscillator sync; the first stage feeds only the second
    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_q;
    logic osc_tick;
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_q <= 1'b0;
        end
        else
        begin
            osc_s1_q <= i_osc_32k;
            osc_s2_q <= osc_s1_q;
            osc_q <= osc_s2_q;
        end
    end
    assign osc_tick = osc_s2_q && !osc_q;

    // ======================================================
    // control, enables and alarm fields
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            control_q <= `RTC_RST_CONTROL;
            alarm_month_q <= `RTC_RST_ALARM_MONTH;
            alarm_date_q <= `RTC_RST_ALARM_DATE;
            alarm_hour_q <= `RTC_RST_ALARM_HOUR;
            alarm_min_q <= `RTC_RST_ALARM_MIN;
            alarm_sec_q <= `RTC_RST_ALARM_SEC;
            square_wave_rate_sel_q <= `RTC_RST_SQW_RATE;
            oscillator_halt_bit_q <= 1'b1;
        end
        else if (i_power_up)
        begin
            control_q[6] <= 1'b0;
            alarm_hour_q[6] <= 1'b1;
        end
        else if (wr_en)
        begin
            if (hit(i_reg_addr, `RTC_ADDR_SECONDS))
                oscillator_halt_bit_q <= i_reg_wdata[7];
            if (hit(i_reg_addr, `RTC_ADDR_CONTROL))
                control_q <= i_reg_wdata;
            if (hit(i_reg_addr, `RTC_ADDR_ALARM_MONTH))
                alarm_month_q <= i_reg_wdata;
            if (hit(i_reg_addr, `RTC_ADDR_ALARM_DATE))
                alarm_date_q <= i_reg_wdata;
            if (hit(i_reg_addr, `RTC_ADDR_ALARM_HOUR))
                alarm_hour_q <= i_reg_wdata;
            if (hit(i_reg_addr, `RTC_ADDR_ALARM_MIN))
                alarm_min_q <= i_reg_wdata;
            if (hit(i_reg_addr, `RTC_ADDR_ALARM_SEC))
                alarm_sec_q <= i_reg_wdata;
            if (hit(i_reg_addr, `RTC_ADDR_SQW_RATE))
                square_wave_rate_sel_q <= i_reg_wdata[7:4];
        end
    end

    // ======================================================
    // century bit
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            century_toggle_enable_q <= 1'b0;
            century_bit_q <= 1'b0;
        end
        else if (wr_en && hit(i_reg_addr, `RTC_ADDR_CENTURY_HOURS))
        begin
            century_toggle_enable_q <= i_reg_wdata[7];
            century_bit_q <= i_reg_wdata[6];
        end
        else if (i_century_tick && century_toggle_enable_q)
            century_bit_q <= ~century_bit_q;
    end

    // ======================================================
    // alarm comparator
    logic [4:0] alarm_repeat_bits;
    logic [4:0] rpt;
    logic alarm_match;
    logic alarm_event;
    assign alarm_repeat_bits = {alarm_date_q[6], alarm_date_q[7],
        alarm_hour_q[7], alarm_min_q[7], alarm_sec_q[7]};
    assign rpt = norm_rpt(alarm_repeat_bits);
    // a field is compared only when its repeat bit is clear
    assign alarm_match = (rpt[0] || i_cur_sec == alarm_sec_q[6:0])
        && (rpt[1] || i_cur_min == alarm_min_q[6:0])
        && (rpt[2] || i_cur_hour == alarm_hour_q[5:0])
        && (rpt[3] || i_cur_date == alarm_date_q[5:0])
        && (rpt[4] || i_cur_month == alarm_month_q[4:0]);
    assign alarm_event = i_sec_tick && alarm_match;

    // a new event wins over a flags read in the same cycle
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            alarm_flag_q <= 1'b0;
            alarm_irq_q <= 1'b0;
        end
        else if (alarm_event)
        begin
            alarm_flag_q <= 1'b1;
            alarm_irq_q <= alarm_irq_enable;
        end
        else if (flags_read)
        begin
            alarm_flag_q <= 1'b0;
            alarm_irq_q <= 1'b0;
        end
    end

    // ======================================================
    // watchdog
    logic [16:0] wd_pre_q;
    logic [4:0] wd_units_q;
    logic [16:0] wd_res_ticks;
    logic wd_unit_done;
    logic wd_timeout;
    // resolution steps by four: 1/16, 1/4, 1 and 4 seconds
    assign wd_res_ticks = 17'(P_WD_BASE_TICKS)
        << {watchdog_resolution, 1'b0};
    assign wd_unit_done = osc_tick && (wd_pre_q == wd_res_ticks - 17'h1);
    assign wd_timeout = wd_unit_done && !wd_irq_q
        && (watchdog_multiplier != 5'h00)
        && (wd_units_q + 5'h1 == watchdog_multiplier);

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            watchdog_q <= `RTC_RST_WATCHDOG;
        else if (i_power_up)
            watchdog_q <= `RTC_RST_WATCHDOG;
        else if (wd_write)
            watchdog_q <= i_reg_wdata[6:0];
    end

    // counter stops once timed out, until a zero write or power-up releases it
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wd_pre_q <= 17'h0;
            wd_units_q <= 5'h0;
        end
        else if (wd_write || i_power_up || watchdog_multiplier == 5'h00)
        begin
            wd_pre_q <= 17'h0;
            wd_units_q <= 5'h0;
        end
        else if (osc_tick && !wd_irq_q)
        begin
            if (wd_unit_done)
            begin
                wd_pre_q <= 17'h0;
                wd_units_q <= wd_timeout ? 5'h0 : wd_units_q + 5'h1;
            end
            else
                wd_pre_q <= wd_pre_q + 17'h1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            wd_irq_q <= 1'b0;
        else if (wd_timeout)
            wd_irq_q <= 1'b1;
        else if ((wd_write && i_reg_wdata == 8'h00) || i_power_up)
            wd_irq_q <= 1'b0;
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            watchdog_flag_q <= 1'b0;
        else if (wd_timeout)
            watchdog_flag_q <= 1'b1;
        else if (flags_read)
            watchdog_flag_q <= 1'b0;
    end

    // ======================================================
    // square wave divider, counts oscillator rising edges
    logic [14:0] sqw_div_q;
    logic sqw_level;
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            sqw_div_q <= 15'h0;
        else if (osc_tick)
            sqw_div_q <= sqw_div_q + 15'h1;
    end

    // 16.384 kHz is skipped: code 2 already taps divide-by-four
    always_comb
    begin
        if (square_wave_rate_sel_q == 4'h0)
            sqw_level = 1'b1;
        else if (square_wave_rate_sel_q == 4'h1)
            sqw_level = osc_q;
        else
            sqw_level = sqw_div_q[square_wave_rate_sel_q - 4'h1];
    end

    // ======================================================
    // pin arbitration
    rtc_pin_src_t src_d;
    logic alarm_visible;
    logic wd_armed;
    assign alarm_visible = alarm_irq_q
        && !hit(i_reg_ptr, `RTC_ADDR_FLAGS);
    assign wd_armed = (watchdog_q != 7'h00);

    always_comb
    begin
        if (i_backup_mode)
            src_d = (alarm_irq_q && alarm_backup_enable && alarm_irq_enable)
                ? RTC_SRC_ALARM : RTC_SRC_RELEASE;
        else if (square_wave_enable)
            src_d = RTC_SRC_SQW;
        else if (alarm_irq_enable && alarm_visible)
            src_d = RTC_SRC_ALARM;
        else if (wd_irq_q)
            src_d = RTC_SRC_WDOG;
        else if (wd_armed || alarm_irq_enable)
            src_d = RTC_SRC_RELEASE;
        else if (freq_test_bit && !oscillator_halt_bit_q)
            src_d = RTC_SRC_FTEST;
        else if (!freq_test_bit)
            src_d = RTC_SRC_OUT;
        else
            src_d = RTC_SRC_RELEASE;
    end

    logic pin_low;
    always_comb
    begin
        unique case (src_d)
            RTC_SRC_SQW: pin_low = !sqw_level;
            RTC_SRC_ALARM: pin_low = 1'b1;
            RTC_SRC_WDOG: pin_low = 1'b1;
            RTC_SRC_FTEST: pin_low = !sqw_div_q[`RTC_FTEST_BIT];
            RTC_SRC_OUT: pin_low = !out_bit;
            default: pin_low = 1'b0;
        endcase
    end

    // open drain: only ever pulls low, released means enable high
    logic pin_oe_n_q;
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            pin_oe_n_q <= 1'b1;
        else
            pin_oe_n_q <= !pin_low;
    end
    assign o_multi_function_pin = 1'b0;
    assign o_multi_function_pin_oe_n = pin_oe_n_q;

    // ======================================================
    // register read path
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            rdata_q <= 8'h00;
        else if (rd_en)
        begin
            unique case (i_reg_addr)
                `RTC_ADDR_SECONDS:
                    rdata_q <= {oscillator_halt_bit_q, i_cur_sec};
                `RTC_ADDR_CENTURY_HOURS:
                    rdata_q <= {century_toggle_enable_q, century_bit_q,
                        i_cur_hour};
                `RTC_ADDR_CONTROL: rdata_q <= control_q;
                `RTC_ADDR_WATCHDOG: rdata_q <= {1'b0, watchdog_q};
                `RTC_ADDR_ALARM_MONTH: rdata_q <= alarm_month_q;
                `RTC_ADDR_ALARM_DATE: rdata_q <= alarm_date_q;
                `RTC_ADDR_ALARM_HOUR: rdata_q <= alarm_hour_q;
                `RTC_ADDR_ALARM_MIN: rdata_q <= alarm_min_q;
                `RTC_ADDR_ALARM_SEC: rdata_q <= alarm_sec_q;
                `RTC_ADDR_FLAGS:
                    rdata_q <= {watchdog_flag_q, alarm_flag_q, 6'h00};
                `RTC_ADDR_SQW_RATE:
                    rdata_q <= {square_wave_rate_sel_q, 4'h0};
                default: rdata_q <= 8'h00;
            endcase
        end
    end
    assign o_reg_rdata = rdata_q;
    assign o_oscillator_halt_bit = oscillator_halt_bit_q;
    assign o_update_freeze_bit = update_freeze_bit;
    assign o_century_bit = century_bit_q;

    // ======================================================
    // checks
    default clocking core_edge @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);

    a_alarm_sets: assert property (
        alarm_event |=> alarm_flag_q)
        else $error("alarm flag not set on match");
    a_flags_read_clears: assert property (
        flags_read && !alarm_event && !wd_timeout
        |=> !alarm_flag_q && !watchdog_flag_q)
        else $error("flags read did not clear flags");
    a_ptr_hides_alarm: assert property (
        hit(i_reg_ptr, `RTC_ADDR_FLAGS) && !i_backup_mode
        |-> src_d != RTC_SRC_ALARM)
        else $error("alarm shown while pointer on flags");
    a_backup_gate: assert property (
        i_backup_mode && !(alarm_backup_enable && alarm_irq_enable)
        |=> o_multi_function_pin_oe_n)
        else $error("pin pulled in back-up without enables");
    a_wd_restart: assert property (
        wd_write |=> wd_pre_q == 17'h0 && wd_units_q == 5'h0)
        else $error("watchdog write did not restart count");
    // a timeout landing with the zero write still sets, as flags do
    a_wd_zero_release: assert property (
        wd_write && i_reg_wdata == 8'h00 && !wd_timeout
        |=> !wd_irq_q ##1 !wd_irq_q)
        else $error("zero write did not release watchdog");
    a_wd_timeout_pin: assert property (
        wd_timeout && !i_backup_mode && !square_wave_enable
        && !(alarm_irq_enable && alarm_visible)
        |=> watchdog_flag_q ##1 !o_multi_function_pin_oe_n)
        else $error("watchdog timeout did not pull pin");
    a_century_flip: assert property (
        i_century_tick && century_toggle_enable_q && !wr_en
        |=> century_bit_q != $past(century_bit_q))
        else $error("century bit did not toggle");
    a_power_up_bits: assert property (
        i_power_up |=> update_freeze_bit && !freq_test_bit
        && watchdog_q == 7'h00)
        else $error("power-up defaults not applied");
    a_sqw_owns_pin: assert property (
        square_wave_enable && !i_backup_mode |-> src_d == RTC_SRC_SQW)
        else $error("square wave not on pin while enabled");

    c_alarm_irq: cover property (alarm_event ##1 alarm_irq_q);
    c_wd_timeout: cover property (wd_timeout);
    c_flags_clear: cover property (alarm_flag_q ##1 flags_read);

endmodule

/* File: bench/rtc_host_model.sv */
/* host side model: hands register reads and writes to the block the way
   the bus engine does, and resolves the open-drain pin.
   assumes a pull-up on the pin and inputs changed at the falling edge. */
`timescale 1ns/1ps
module rtc_host_model (
    // clock
    input wire logic i_core_clk,
    // register access
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_ptr,
    input wire logic [7:0] i_rdata,
    // pin
    input wire logic i_pin_oe_n,
    input wire logic i_pin_data,
    output logic o_pin_level
);
    // ==========================================================
    // open drain: the pull-up holds the line high once released
    assign o_pin_level = i_pin_oe_n ? 1'b1 : i_pin_data;
    initial
    begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_ptr = 8'h00;
    end
    // ==========================================================
    // accesses; pointer steps past the register, as auto-increment does
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_core_clk);
        o_wr = 1'b0;
        o_ptr = a + 8'h01;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_core_clk);
        o_rd = 1'b0;
        o_ptr = a + 8'h01;
        @(negedge i_core_clk);
        d = i_rdata;
    endtask
    // any watchdog write restarts it, zero releases and disables it
    task automatic wd_kick(input logic [7:0] d);
        wr(8'h09, d);
    endtask
endmodule

/* File: bench/rtc_event_ctrl_tb.sv */
/* testbench: each alarm repeat case with a random mismatching field, plus hand-picked corners for the
   watchdog, pin sources, century bit and power-up defaults.
   assumes the host model is compiled first; short watchdog base count. */
`timescale 1ns/1ps
module rtc_event_ctrl_tb;
    localparam int BASE = 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic osc = 1'b0;
    logic pwr = 1'b0;
    logic bkp = 1'b0;
    logic stk = 1'b0;
    logic ctk = 1'b0;
    logic [6:0] sec = 7'h00;
    logic [6:0] mn = 7'h00;
    logic [5:0] hr = 6'h00;
    logic [5:0] dt = 6'h00;
    logic [4:0] mo = 5'h00;
    logic [7:0] addr, wdata, ptr, rdata;
    logic wr_s, rd_s, oe_n, pdat, pin, halt, frz, cent, e;
    logic [4:0] rpt;
    int error_cnt = 0;
    int checks = 0;
    int oscn = 0;
    int sd = 7;
    int j, n, t;
    always #12.5 clk = ~clk;
    // oscillator made fast on purpose, toggling 3 ns after every fourth core clock rising edge
    always
    begin
        repeat (4) @(posedge clk);
        #3 osc = ~osc;
    end
    always @(posedge osc) oscn++;
    rtc_event_ctrl #(.P_WD_BASE_TICKS(BASE)) rtc_event_ctrl_i (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_osc_32k(osc),
        .i_power_up(pwr), .i_backup_mode(bkp), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr_s), .i_reg_rd(rd_s),
        .i_reg_ptr(ptr), .o_reg_rdata(rdata), .i_sec_tick(stk),
        .i_century_tick(ctk), .i_cur_sec(sec), .i_cur_min(mn),
        .i_cur_hour(hr), .i_cur_date(dt), .i_cur_month(mo),
        .o_oscillator_halt_bit(halt), .o_update_freeze_bit(frz),
        .o_century_bit(cent), .o_multi_function_pin(pdat),
        .o_multi_function_pin_oe_n(oe_n));
    rtc_host_model rtc_host_model_i (
        .i_core_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr_s),
        .o_rd(rd_s), .o_ptr(ptr), .i_rdata(rdata), .i_pin_oe_n(oe_n),
        .i_pin_data(pdat), .o_pin_level(pin));
    // ==========================================================
    // helpers
    function automatic logic exp_alarm(input int k, input int j);
        // undefined codes compare no field, like every second
        return j >= ((k < 6) ? k : 0);
    endfunction
    task automatic conclude();
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkc(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi)
        begin
            error_cnt++;
            $display("mismatch at %0t: count %0d outside %0d..%0d",
                $time, got, lo, hi);
        end
    endtask
    task automatic settle();
        repeat (2) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        settle();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        rtc_host_model_i.wr(a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rtc_host_model_i.rd(a, d);
        chk(d, exp);
    endtask
    task automatic wpin(input logic lvl);
        int k = 0;
        while (pin !== lvl && k < 5000)
        begin
            @(negedge clk);
            k++;
        end
    endtask
    // osc edges between two pin changes, first change skipped as ragged
    task automatic half(input int h);
        logic l;
        l = pin;
        wpin(!l);
        t = oscn;
        wpin(l);
        chkc(oscn - t, h - 1, h + 1);
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        fork
        begin
            #1_000_000;
            error_cnt++;
            conclude();
        end
        join_none
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rdc(8'h08, 8'h80);
        rdc(8'h09, 8'h00);
        rdc(8'h0a, 8'h00);
        rdc(8'h10, 8'h00);
        chk({5'h0, pin, halt, frz}, 8'h07);
        wr(8'h08, 8'h00);
        settle();
        chk({7'h0, pin}, 8'h00);
        wr(8'h08, 8'h80);
        wr(8'h01, 8'h00);
        for (int k = 0; k < 7; k++)
        begin
            j = $unsigned($random(sd)) % 5;
            rpt = (k < 6) ? (5'h1f << k) : 5'h0a;
            wr(8'h0e, {rpt[0], 7'h11});
            wr(8'h0d, {rpt[1], 7'h22});
            wr(8'h0c, {rpt[2], 1'b0, 6'h13});
            wr(8'h0b, {rpt[3], rpt[4], 6'h14});
            wr(8'h0a, 8'h85);
            sec = (j == 0) ? 7'h12 : 7'h11;
            mn = (j == 1) ? 7'h23 : 7'h22;
            hr = (j == 2) ? 6'h14 : 6'h13;
            dt = (j == 3) ? 6'h15 : 6'h14;
            mo = (j == 4) ? 5'h06 : 5'h05;
            e = exp_alarm(k, j);
            pulse(stk);
            chk({7'h0, pin}, {7'h0, !e});
            rdc(8'h0f, {1'b0, e, 6'h00});
            settle();
            chk({7'h0, pin}, 8'h01);
            rdc(8'h0f, 8'h00);
        end
        wr(8'h0e, 8'h11);
        pulse(stk);
        chk({7'h0, pin}, 8'h01);
        rdc(8'h08, 8'h80);
        settle();
        chk({7'h0, pin}, 8'h00);
        rdc(8'h0f, 8'h40);
        bkp = 1'b1;
        wr(8'h0a, 8'ha5);
        pulse(stk);
        chk({7'h0, pin}, 8'h00);
        rdc(8'h0f, 8'h40);
        wr(8'h0a, 8'h85);
        pulse(stk);
        chk({7'h0, pin}, 8'h01);
        rdc(8'h0f, 8'h40);
        bkp = 1'b0;
        wr(8'h0a, 8'h00);
        for (int r = 0; r < 4; r++)
        begin
            n = 3 * BASE * (4 ** r);
            wr(8'h08, 8'h40);
            rtc_host_model_i.wd_kick({1'b0, 5'd3, r[1:0]});
            if (r == 0)
            begin
                repeat (4) @(posedge osc);
                rtc_host_model_i.wd_kick(8'h0c);
            end
            settle();
            t = oscn;
            wpin(1'b0);
            chkc(oscn - t, n - 2, n);
            rdc(8'h0f, 8'h80);
            chk({7'h0, pin}, 8'h00);
            wr(8'h08, 8'h80);
            rtc_host_model_i.wd_kick(8'h00);
            settle();
            chk({7'h0, pin}, 8'h01);
        end
        wr(8'h13, 8'h20);
        wr(8'h08, 8'h40);
        half(32);
        wr(8'h0a, 8'h40);
        for (int c = 1; c < 7; c++)
        begin
            wr(8'h13, {c[3:0], 4'h0});
            half(1 << (c - 1));
        end
        rdc(8'h13, 8'h60);
        wr(8'h13, 8'h00);
        repeat (3) @(posedge osc);
        chk({7'h0, pin}, 8'h01);
        wr(8'h03, 8'h80);
        pulse(ctk);
        chk({7'h0, cent}, 8'h01);
        wr(8'h03, 8'h40);
        pulse(ctk);
        chk({7'h0, cent}, 8'h01);
        wr(8'h09, 8'h0e);
        wr(8'h0a, 8'hc5);
        pulse(pwr);
        rdc(8'h09, 8'h00);
        rdc(8'h08, 8'h00);
        rdc(8'h0a, 8'hc5);
        chk({6'h0, halt, frz}, 8'h01);
        conclude();
    end
endmodule
